// >>> qbs_map.svh
// Purpose: constants for the burst sram port logic
// Assumes: narrow part, 18-bit words, 19-bit address
// Notes:   definitions only
`ifndef QBS_MAP_SVH
`define QBS_MAP_SVH

`define QBS_DATA_W     18
`define QBS_ADDR_W     19
`define QBS_BYTE_W     9
`define QBS_NBYTE      2
`define QBS_BURST      4
`define QBS_BEAT_W     20
`define QBS_BURST_W    72
`define QBS_WR_ENTRY_W 99
`define QBS_MEM_AW     21
`define QBS_FIFO_DEPTH 32

`endif

// >>> qbs_pkg.sv
// Purpose: types shared by the burst sram port logic
// Assumes: constants live in qbs_map.svh
// Notes:   core sequencer states are one-hot
package qbs_pkg;

  typedef enum logic [3:0] {
    QBS_IDLE  = 4'h1,
    QBS_WRITE = 4'h2,
    QBS_READ  = 4'h4,
    QBS_PUSH  = 4'h8
  } qbs_core_st_t;

endpackage

// >>> qbs_port.sv
// Purpose: port logic of a burst sram, ddr read and write ports
// Assumes: k_clk free running; core clock 250 MHz; rst_n synchronous
// Notes:   link side on k_clk edges, array and sequencer on clock
`timescale 1ns/1ps
`include "qbs_map.svh"

// async fifo, gray pointers crossing both ways
module qbs_afifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // fill side
  input  wire logic             wclk,
  input  wire logic             wrst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wbin_q;
  logic [AW:0]      wgray_q;
  logic [AW:0]      rbin_q;
  logic [AW:0]      rgray_q;
  logic [AW:0]      rg_s1_q;
  logic [AW:0]      rg_s2_q;
  logic [AW:0]      wg_s1_q;
  logic [AW:0]      wg_s2_q;
  logic [AW:0]      wbin_d;
  logic [AW:0]      rbin_d;
  logic             push;
  logic             pop;

  // full: top two gray bits inverted, rest equal
  assign in_ready  = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
  assign out_valid = (rgray_q != wg_s2_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign wbin_d    = wbin_q + {{AW{1'b0}}, push};
  assign rbin_d    = rbin_q + {{AW{1'b0}}, pop};
  assign out_data  = mem[rbin_q[AW-1:0]];

  always_ff @(posedge wclk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge wclk) begin
    if (!wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
    end
  end

  always_ff @(posedge rclk) begin
    if (!rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rbin_d ^ (rbin_d >> 1);
    end
  end

  // first stage read only by second stage
  always_ff @(posedge wclk) begin
    if (!wrst_n) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  always_ff @(posedge rclk) begin
    if (!rrst_n) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule

module qbs_port
  import qbs_pkg::*;
(
  // core clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // link clock and controls
  input  wire logic                      k_clk,
  input  wire logic                      write_port_select_n,
  input  wire logic                      read_port_select_n,
  input  wire logic [`QBS_ADDR_W-1:0]    address,
  // write port
  input  wire logic [`QBS_DATA_W-1:0]    write_data,
  input  wire logic [`QBS_NBYTE-1:0]     byte_write_select_n,
  // read port
  output logic [`QBS_DATA_W-1:0]         read_data,
  output logic                           read_data_oe,
  output logic                           output_valid_flag,
  // echo clocks
  output logic                           echo_timer_out,
  output logic                           echo_timer_out_n
);
  // link reset, rst_n brought over by two flops
  logic                       krst_s1_q;
  logic                       krst_n_q;
  // write capture
  logic [`QBS_BEAT_W-1:0]     wbeat_fall_q;
  logic [1:0]                 wr_ph_q;
  logic [`QBS_ADDR_W-1:0]     wr_addr_q;
  logic [3*`QBS_BEAT_W-1:0]   wr_beats_q;
  logic                       wr_push_q;
  logic [`QBS_WR_ENTRY_W-1:0] wr_push_data_q;
  logic                       wf_in_ready;
  logic                       wr_start;
  logic                       rd_start;
  // read request and return
  logic                       rq_in_ready;
  logic                       ret_valid;
  logic                       ret_pop;
  logic [`QBS_BURST_W-1:0]    ret_data;
  logic [`QBS_BURST_W-1:0]    rd_burst_q;
  logic                       rd_on_q;
  logic                       rd_first_q;
  logic [`QBS_DATA_W-1:0]     q_rise_q;
  logic [`QBS_DATA_W-1:0]     q_fall_q;
  logic                       vld_fall_q;
  // core side
  qbs_core_st_t               st_q;
  logic [1:0]                 idx_q;
  logic [`QBS_WR_ENTRY_W-1:0] wbuf_q;
  logic [`QBS_ADDR_W-1:0]     raddr_q;
  logic [`QBS_BURST_W-1:0]    rbuf_q;
  logic                       wf_out_valid;
  logic [`QBS_WR_ENTRY_W-1:0] wf_out_data;
  logic                       rq_out_valid;
  logic [`QBS_ADDR_W-1:0]     rq_out_data;
  logic                       ret_in_ready;
  logic                       wf_pop;
  logic                       rq_pop;
  logic [`QBS_MEM_AW-1:0]     waddr;
  logic [`QBS_MEM_AW-1:0]     raddr;
  logic [`QBS_BEAT_W-1:0]     cur_beat;
  logic [`QBS_DATA_W-1:0]     merged;

  // one array; the low two word-address bits pick the beat within a burst
  logic [`QBS_DATA_W-1:0] mem [0:(1 << `QBS_MEM_AW)-1];

  always_ff @(posedge k_clk) begin
    krst_s1_q <= rst_n;
    krst_n_q  <= krst_s1_q;
  end

  // echo clocks follow k directly, so they never stop
  assign echo_timer_out   = k_clk;
  assign echo_timer_out_n = ~k_clk;

  // read wins the shared address if both selects are low
  assign rd_start = !read_port_select_n && rq_in_ready;
  assign wr_start = !write_port_select_n && read_port_select_n
                    && (wr_ph_q != 2'h1)
                    && (!wr_push_q || wf_in_ready);

  // k-bar rising edge is the falling edge of k
  always_ff @(negedge k_clk) begin
    wbeat_fall_q <= {byte_write_select_n, write_data};
  end

  always_ff @(posedge k_clk) begin
    if (!krst_n_q) begin
      wr_ph_q <= 2'h0;
    end else if (wr_start) begin
      wr_ph_q <= 2'h1;
    end else if (wr_ph_q == 2'h1) begin
      wr_ph_q <= 2'h2;
    end else begin
      wr_ph_q <= 2'h0;
    end
  end

  // beats 0 and 2 on k rise, 1 and 3 on k-bar rise
  always_ff @(posedge k_clk) begin
    if (wr_start) begin
      wr_addr_q <= address;
      wr_beats_q[`QBS_BEAT_W-1:0] <= {byte_write_select_n, write_data};
    end else if (wr_ph_q == 2'h1) begin
      wr_beats_q[2*`QBS_BEAT_W-1:`QBS_BEAT_W]   <= wbeat_fall_q;
      wr_beats_q[3*`QBS_BEAT_W-1:2*`QBS_BEAT_W] <=
        {byte_write_select_n, write_data};
    end
  end

  // a deselected cycle never reaches the push register
  always_ff @(posedge k_clk) begin
    if (!krst_n_q) begin
      wr_push_q <= 1'b0;
    end else if (wr_ph_q == 2'h2) begin
      wr_push_q <= 1'b1;
    end else if (wf_in_ready) begin
      wr_push_q <= 1'b0;
    end
  end

  always_ff @(posedge k_clk) begin
    if (wr_ph_q == 2'h2) begin
      wr_push_data_q <= {wr_addr_q, wbeat_fall_q, wr_beats_q};
    end
  end

  // pop a whole burst unless one is mid-flight
  assign ret_pop = ret_valid && !(rd_on_q && rd_first_q);

  always_ff @(posedge k_clk) begin
    if (!krst_n_q) begin
      rd_on_q    <= 1'b0;
      rd_first_q <= 1'b0;
    end else if (rd_on_q && rd_first_q) begin
      rd_first_q <= 1'b0;
    end else if (ret_pop) begin
      rd_on_q    <= 1'b1;
      rd_first_q <= 1'b1;
    end else begin
      rd_on_q    <= 1'b0;
      rd_first_q <= 1'b0;
    end
  end

  always_ff @(posedge k_clk) begin
    if (rd_on_q && rd_first_q) begin
      q_rise_q <= rd_burst_q[3*`QBS_DATA_W-1:2*`QBS_DATA_W];
    end else if (ret_pop) begin
      rd_burst_q <= ret_data;
      q_rise_q   <= ret_data[`QBS_DATA_W-1:0];
    end
  end

  always_ff @(negedge k_clk) begin
    if (rd_first_q) begin
      q_fall_q <= rd_burst_q[2*`QBS_DATA_W-1:`QBS_DATA_W];
    end else begin
      q_fall_q <= rd_burst_q[4*`QBS_DATA_W-1:3*`QBS_DATA_W];
    end
  end

  always_ff @(negedge k_clk) begin
    if (!krst_n_q) begin
      vld_fall_q <= 1'b0;
    end else begin
      vld_fall_q <= rd_on_q;
    end
  end

  // ddr launch: k high shows the rise half, k low the fall half
  assign read_data         = k_clk ? q_rise_q : q_fall_q;
  assign output_valid_flag = k_clk ? rd_on_q : vld_fall_q;
  assign read_data_oe      = k_clk ? rd_on_q : vld_fall_q;

  qbs_afifo #(
    .WIDTH (`QBS_WR_ENTRY_W),
    .DEPTH (`QBS_FIFO_DEPTH)
  ) u_wr_fifo (
    .wclk      (k_clk),
    .wrst_n    (krst_n_q),
    .in_valid  (wr_push_q),
    .in_ready  (wf_in_ready),
    .in_data   (wr_push_data_q),
    .rclk      (clock),
    .rrst_n    (rst_n),
    .out_valid (wf_out_valid),
    .out_ready (wf_pop),
    .out_data  (wf_out_data)
  );

  // address only enters when its port is selected
  qbs_afifo #(
    .WIDTH (`QBS_ADDR_W),
    .DEPTH (`QBS_FIFO_DEPTH)
  ) u_rq_fifo (
    .wclk      (k_clk),
    .wrst_n    (krst_n_q),
    .in_valid  (rd_start),
    .in_ready  (rq_in_ready),
    .in_data   (address),
    .rclk      (clock),
    .rrst_n    (rst_n),
    .out_valid (rq_out_valid),
    .out_ready (rq_pop),
    .out_data  (rq_out_data)
  );

  qbs_afifo #(
    .WIDTH (`QBS_BURST_W),
    .DEPTH (`QBS_FIFO_DEPTH)
  ) u_ret_fifo (
    .wclk      (clock),
    .wrst_n    (rst_n),
    .in_valid  (st_q == QBS_PUSH),
    .in_ready  (ret_in_ready),
    .in_data   (rbuf_q),
    .rclk      (k_clk),
    .rrst_n    (krst_n_q),
    .out_valid (ret_valid),
    .out_ready (ret_pop),
    .out_data  (ret_data)
  );

  // writes first when both queues hold an entry; a read issued right after a write enters its queue a k cycle before the write does
  assign wf_pop = (st_q == QBS_IDLE) && wf_out_valid;
  assign rq_pop = (st_q == QBS_IDLE) && !wf_out_valid && rq_out_valid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q  <= QBS_IDLE;
      idx_q <= 2'h0;
    end else begin
      unique case (st_q)
        QBS_IDLE: begin
          idx_q <= 2'h0;
          if (wf_pop) begin
            st_q <= QBS_WRITE;
          end else if (rq_pop) begin
            st_q <= QBS_READ;
          end
        end
        QBS_WRITE: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'h3) begin
            st_q <= QBS_IDLE;
          end
        end
        QBS_READ: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'h3) begin
            st_q <= QBS_PUSH;
          end
        end
        QBS_PUSH: begin
          if (ret_in_ready) begin
            st_q <= QBS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (wf_pop) begin
      wbuf_q <= wf_out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rq_pop) begin
      raddr_q <= rq_out_data;
    end
  end

  assign waddr    = {wbuf_q[`QBS_WR_ENTRY_W-1:4*`QBS_BEAT_W], idx_q};
  assign raddr    = {raddr_q, idx_q};
  assign cur_beat = wbuf_q[idx_q*`QBS_BEAT_W +: `QBS_BEAT_W];

  // per-byte merge keeps bytes whose select is high
  for (genvar b = 0; b < `QBS_NBYTE; b++) begin : g_byte
    assign merged[b*`QBS_BYTE_W +: `QBS_BYTE_W] =
      cur_beat[`QBS_DATA_W + b] ?
      mem[waddr][b*`QBS_BYTE_W +: `QBS_BYTE_W] :
      cur_beat[b*`QBS_BYTE_W +: `QBS_BYTE_W];
  end

  always_ff @(posedge clock) begin
    if (st_q == QBS_WRITE) begin
      mem[waddr] <= merged;
    end
  end

  always_ff @(posedge clock) begin
    if (st_q == QBS_READ) begin
      rbuf_q[idx_q*`QBS_DATA_W +: `QBS_DATA_W] <= mem[raddr];
    end
  end

endmodule

// >>> qbs_port_props.sv
// Purpose: port checks for qbs_port
// Assumes: k_clk free running, rst_n synchronous on clock
// Notes:   k-domain checks sample at k rise
`timescale 1ns/1ps
`include "qbs_map.svh"
module qbs_port_props (
  // clocks and reset
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   k_clk,
  // link inputs
  input wire logic                   write_port_select_n,
  input wire logic                   read_port_select_n,
  input wire logic [`QBS_ADDR_W-1:0] address,
  input wire logic [`QBS_DATA_W-1:0] write_data,
  input wire logic [`QBS_NBYTE-1:0]  byte_write_select_n,
  // read port and echoes
  input wire logic [`QBS_DATA_W-1:0] read_data,
  input wire logic                   read_data_oe,
  input wire logic                   output_valid_flag,
  input wire logic                   echo_timer_out,
  input wire logic                   echo_timer_out_n
);
  logic [7:0] run_q;
  logic       seen_q;
  // run length wraps; only its parity matters
  always_ff @(posedge k_clk) begin
    if (!rst_n) run_q <= 8'h00;
    else run_q <= output_valid_flag ? run_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge k_clk) begin
    if (!rst_n) seen_q <= 1'b0;
    else if (!read_port_select_n) seen_q <= 1'b1;
  end
  oe_match_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    read_data_oe == output_valid_flag) else $error("oe differs from valid");
  echo_follow_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    echo_timer_out == k_clk && echo_timer_out_n == !k_clk)
    else $error("echo clocks do not follow k");
  valid_edge_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    $changed(output_valid_flag) |-> $rose(k_clk))
    else $error("valid moved off a k rise");
  data_still_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    read_data_oe && $stable(k_clk) |-> $stable(read_data))
    else $error("read data moved between k edges");
  read_answer_a:
  assert property (@(posedge k_clk) disable iff (!rst_n)
    !read_port_select_n |-> ##[1:80] output_valid_flag)
    else $error("read request got no burst");
  burst_hold_a:
  assert property (@(posedge k_clk) disable iff (!rst_n)
    $rose(output_valid_flag) |=> output_valid_flag)
    else $error("burst cut short");
  burst_even_a:
  assert property (@(posedge k_clk) disable iff (!rst_n)
    !output_valid_flag && run_q != 8'h00 |-> !run_q[0])
    else $error("burst not a whole four words");
  valid_cause_a:
  assert property (@(posedge k_clk) disable iff (!rst_n)
    $rose(output_valid_flag) |-> seen_q)
    else $error("valid without any read");
endmodule
bind qbs_port qbs_port_props i_qbs_port_props (.*);

// >>> qbs_ctrl_model.sv
// Purpose: memory controller model driving the link
// Assumes: k period 64 ns, launches 1 ns after each k edge
// Notes:   released address lines carry inverted values; idle inverts address, data and byte selects each cycle
`timescale 1ns/1ps
`include "qbs_map.svh"
module qbs_ctrl_model (
  // link clock and controls
  output logic                       k_clk,
  output logic                       write_port_select_n,
  output logic                       read_port_select_n,
  output logic [`QBS_ADDR_W-1:0]     address,
  output logic [`QBS_DATA_W-1:0]     write_data,
  output logic [`QBS_NBYTE-1:0]      byte_write_select_n,
  // read side
  input wire logic [`QBS_DATA_W-1:0] read_data,
  input wire logic                   output_valid_flag
);
  logic [`QBS_DATA_W-1:0] rq[$];
  initial begin
    k_clk = 1'b0;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    address = 19'h00000;
    write_data = 18'h00000;
    byte_write_select_n = 2'h3;
    #1.3;
    forever #32 k_clk = ~k_clk;
  end
  // sample mid half-cycle, clear of the launching edge
  always @(k_clk) begin
    #16;
    if (output_valid_flag === 1'b1) rq.push_back(read_data);
  end
  task automatic wr(input logic [`QBS_ADDR_W-1:0] a,
                    input logic [71:0] d, input logic [7:0] be);
    for (int i = 0; i < 4; i++) begin
      if (i[0]) @(posedge k_clk);
      else @(negedge k_clk);
      #1;
      write_data = d[18*i +: 18];
      byte_write_select_n = be[2*i +: 2];
      if (i == 0) write_port_select_n = 1'b0;
      if (i == 0) address = a;
      if (i == 1) write_port_select_n = 1'b1;
      if (i == 1) address = ~a;
    end
  endtask
  task automatic rd(input logic [`QBS_ADDR_W-1:0] a);
    @(negedge k_clk);
    #1;
    read_port_select_n = 1'b0;
    address = a;
    @(posedge k_clk);
    #1;
    read_port_select_n = 1'b1;
    address = ~a;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge k_clk);
      #1;
      address = ~address;
      write_data = ~write_data;
      byte_write_select_n = ~byte_write_select_n;
    end
  endtask
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for qbs_port
// Assumes: controller model drives the link, bench drives reset
// Notes:   expected words built from the write patterns
`timescale 1ns/1ps
`include "qbs_map.svh"
`define CHK(nm, e, s) begin \
  n_checks++; \
  if ((s) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, s); \
  end \
end
module testbench;
  localparam logic [18:0] A_HI = 19'h7FFFF;
  localparam logic [18:0] A_LO = 19'h00000;
  localparam logic [18:0] A_MID = 19'h2AAAA;
  localparam logic [71:0] D1 = 72'h0123456789ABCDEF5A;
  localparam logic [71:0] D2 = 72'hFEDCBA9876543210A5;
  localparam logic [7:0]  BE = 8'h6C;
  logic        clock, rst_n, k_clk, wsel_n, rsel_n, oe, vld, eo, eo_n;
  logic [18:0] address;
  logic [17:0] write_data, read_data;
  logic [1:0]  bsel_n;
  int          mismatches, n_checks, cyc;
  qbs_port i_qbs_port (.clock(clock), .rst_n(rst_n), .k_clk(k_clk),
    .write_port_select_n(wsel_n), .read_port_select_n(rsel_n),
    .address(address), .write_data(write_data),
    .byte_write_select_n(bsel_n), .read_data(read_data),
    .read_data_oe(oe), .output_valid_flag(vld),
    .echo_timer_out(eo), .echo_timer_out_n(eo_n));
  qbs_ctrl_model i_qbs_ctrl_model (.k_clk(k_clk),
    .write_port_select_n(wsel_n), .read_port_select_n(rsel_n),
    .address(address), .write_data(write_data),
    .byte_write_select_n(bsel_n), .read_data(read_data),
    .output_valid_flag(vld));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [71:0] d);
    int          w;
    logic [17:0] g;
    w = 0;
    while (i_qbs_ctrl_model.rq.size() < 4 && w < 4000) begin
      @(posedge clock);
      w++;
    end
    for (int i = 0; i < 4; i++) begin
      g = i_qbs_ctrl_model.rq.size() > 0 ?
          i_qbs_ctrl_model.rq.pop_front() : ~d[18*i +: 18];
      `CHK("burst word", d[18*i +: 18], g)
    end
  endtask
  task automatic s_write_read();
    i_qbs_ctrl_model.wr(A_HI, D1, 8'h00);
    i_qbs_ctrl_model.idle(3);
    i_qbs_ctrl_model.rd(A_HI);
    chk(D1);
  endtask
  task automatic s_bytes();
    logic [71:0] e;
    for (int j = 0; j < 8; j++) begin
      e[9*j +: 9] = BE[j] ? D1[9*j +: 9] : D2[9*j +: 9];
    end
    i_qbs_ctrl_model.wr(A_LO, D1, 8'h00);
    i_qbs_ctrl_model.wr(A_LO, D2, BE);
    i_qbs_ctrl_model.idle(1);
    i_qbs_ctrl_model.rd(A_LO);
    chk(e);
  endtask
  // back-to-back writes then reads; released address lines carry the inverted address
  task automatic s_back_to_back();
    i_qbs_ctrl_model.wr(A_MID, D2, 8'h00);
    i_qbs_ctrl_model.wr(A_HI, D2, 8'hFF);
    i_qbs_ctrl_model.rd(A_MID);
    i_qbs_ctrl_model.rd(A_HI);
    chk(D2);
    chk(D1);
  endtask
  initial begin
    rst_n = 1'b0;
    cyc = 0;
    mismatches = 0;
    n_checks = 0;
    // longer than four cycles: the k side needs three k rises too
    repeat (64) @(posedge clock);
    `CHK("oe in reset", 1'b0, oe)
    #1 rst_n = 1'b1;
    repeat (4) @(posedge k_clk);
    s_write_read();
    s_bytes();
    s_back_to_back();
    repeat (2) @(posedge k_clk);
    // look after the edge, once the launched values have settled
    #1;
    `CHK("extra words", 32'd0, i_qbs_ctrl_model.rq.size())
    `CHK("oe idle", 1'b0, oe)
    `CHK("echo at k high", 1'b1, eo)
    `CHK("echo bar at k high", 1'b0, eo_n)
    @(negedge k_clk);
    #1;
    `CHK("echo at k low", 1'b0, eo)
    `CHK("echo bar at k low", 1'b1, eo_n)
    `CHK("oe idle at k low", 1'b0, oe)
    complete_run();
  end
endmodule
